/* File: serial_config_port.sv */
// Three-wire serial configuration port with shadowed requantizer registers.
// Assumes the serial clock runs at most an eighth of ref_clk_in; all pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module serial_config_port #(
   parameter int unsigned SECONDARY_IDLE = serial_config_pkg::SECONDARY_IDLE_CYCLES,
   parameter logic [7:0] CHIP_ID = 8'h5A // Arbitrary identification value.
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Serial pins; the data pin is split into input, output and enable.
   input wire logic sclk_in,
   input wire logic chip_select_n_in,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   // Pins are free for their secondary function.
   output logic secondary_function_out,
   // Port configuration state.
   output logic lsb_first_out,
   // Requantizer controls taken from the live registers.
   output logic noise_shaping_requantizer_en_out,
   output logic bw33_mode_out,
   output logic [5:0] band_tuning_word_out,
   output logic tuning_valid_out,
   output logic [8:0] left_edge_thousandths_out,
   output logic [2:0] atten_tenth_db_out,
   output logic [3:0] latency_cycles_out
);

   // Refuse an idle count the 12-bit counter cannot hold.
   if (SECONDARY_IDLE < 1 || SECONDARY_IDLE > 4095) begin : g_bad_idle
      $error("SECONDARY_IDLE must lie between 1 and 4095");
   end

   localparam logic [11:0] IDLE_MAX = 12'(SECONDARY_IDLE);

   // All state of the port in one record.
   typedef struct packed {
      serial_config_pkg::phase_t phase;
      logic [4:0] bit_cnt;
      logic [15:0] shift;
      logic rd;
      logic [1:0] word_len;
      logic [12:0] addr;
      logic [1:0] bytes_left;
      logic [7:0] out_byte;
      logic sdio_o;
      logic sdio_oe;
      logic sclk_q;
      logic lsb_first;
      logic [7:0] ctrl_shadow;
      logic [7:0] tune_shadow;
      logic [7:0] ctrl_live;
      logic [7:0] tune_live;
      logic [11:0] idle_cnt;
      logic secondary;
   } state_t;

   localparam state_t S_RESET = '{
      phase: serial_config_pkg::ST_IDLE,
      ctrl_shadow: serial_config_pkg::REQ_CTRL_RESET,
      tune_shadow: serial_config_pkg::REQ_TUNE_RESET,
      ctrl_live: serial_config_pkg::REQ_CTRL_RESET,
      tune_live: serial_config_pkg::REQ_TUNE_RESET,
      default: '0
   };

   state_t s;
   state_t next_s;
   logic sclk_s;
   logic cs_n_s;
   logic din_s;
   logic rise;
   logic fall;
   logic [15:0] instr_word;
   logic [7:0] data_byte;
   logic [12:0] next_addr;

   // Pins cross into the reference domain before anything reads them.
   pin_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h2)
   ) u_pin_sync (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .async_in({sclk_in, chip_select_n_in, sdio_in}),
      .sync_out({sclk_s, cs_n_s, din_s})
   );

   // Serial clock edges, found on the synchronised level.
   assign rise = sclk_s & ~s.sclk_q;
   assign fall = ~sclk_s & s.sclk_q;

   // Incoming bit joins the word at the end that matches the bit order.
   assign instr_word = s.lsb_first ? {din_s, s.shift[15:1]} : {s.shift[14:0], din_s};
   assign data_byte = s.lsb_first ? {din_s, s.shift[7:1]} : {s.shift[6:0], din_s};

   // Streaming walks addresses up in LSB-first order and down in MSB-first order.
   assign next_addr = s.lsb_first ? s.addr + 13'h0001 : s.addr - 13'h0001;

   // Readback value of one byte location; unmapped places and the transfer byte read zero.
   function automatic logic [7:0] read_reg(input logic [12:0] a, input state_t st);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         serial_config_pkg::ADDR_PORT_CFG: begin
            v = serial_config_pkg::PORT_CFG_DEFAULT;
            v[serial_config_pkg::LSB_FIRST_HI] = st.lsb_first;
            v[serial_config_pkg::LSB_FIRST_LO] = st.lsb_first;
         end
         serial_config_pkg::ADDR_CHIP_ID: begin
            v = CHIP_ID;
         end
         serial_config_pkg::ADDR_REQ_CTRL: begin
            v = st.ctrl_shadow;
         end
         serial_config_pkg::ADDR_REQ_TUNE: begin
            v = st.tune_shadow;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction : read_reg

   // Next state of the whole port.
   always_comb begin
      next_s = s;
      next_s.sclk_q = sclk_s;
      if (cs_n_s) begin
         // Deselected: the pin is released and serial clock activity is ignored.
         next_s.sdio_oe = 1'b0;
         if (s.idle_cnt != IDLE_MAX) begin
            next_s.idle_cnt = s.idle_cnt + 12'h001;
         end else begin
            next_s.secondary = 1'b1;
         end
         // A byte cut short is dropped; a byte boundary keeps the frame for a resume.
         if (s.bit_cnt[2:0] != 3'h0) begin
            next_s.phase = serial_config_pkg::ST_IDLE;
            next_s.bit_cnt = 5'h00;
         end
      end else begin
         next_s.idle_cnt = 12'h000;
         next_s.secondary = 1'b0;
         if (s.phase == serial_config_pkg::ST_IDLE) begin
            // Chip select has fallen; the next rising edge is the first bit.
            next_s.phase = serial_config_pkg::ST_INSTR;
            next_s.bit_cnt = 5'h00;
         end else if (rise) begin
            case (s.phase)
               serial_config_pkg::ST_INSTR: begin
                  next_s.shift = instr_word;
                  if (s.bit_cnt == 5'(serial_config_pkg::INSTR_BITS - 1)) begin
                     // Instruction complete: direction, length and start address.
                     next_s.rd = instr_word[serial_config_pkg::INSTR_RW_BIT];
                     next_s.word_len = instr_word[serial_config_pkg::INSTR_WL_HI:serial_config_pkg::INSTR_WL_LO];
                     next_s.bytes_left = instr_word[serial_config_pkg::INSTR_WL_HI:serial_config_pkg::INSTR_WL_LO];
                     next_s.addr = instr_word[12:0];
                     next_s.out_byte = read_reg(instr_word[12:0], s);
                     next_s.bit_cnt = 5'h00;
                     next_s.phase = serial_config_pkg::ST_DATA;
                  end else begin
                     next_s.bit_cnt = s.bit_cnt + 5'h01;
                  end
               end
               serial_config_pkg::ST_DATA: begin
                  next_s.shift = {8'h00, data_byte};
                  if (s.bit_cnt == 5'(serial_config_pkg::WORD_BITS - 1)) begin
                     next_s.bit_cnt = 5'h00;
                     if (!s.rd) begin
                        // A whole byte has arrived: store it.
                        case (s.addr)
                           serial_config_pkg::ADDR_PORT_CFG: begin
                              // Either mirrored copy of a bit is enough to set it.
                              next_s.lsb_first = data_byte[serial_config_pkg::LSB_FIRST_HI]
                                 | data_byte[serial_config_pkg::LSB_FIRST_LO];
                              if (data_byte[serial_config_pkg::SOFT_RST_HI]
                                  | data_byte[serial_config_pkg::SOFT_RST_LO]) begin
                                 // Soft reset restores defaults and clears itself at once.
                                 next_s.lsb_first = 1'b0;
                                 next_s.ctrl_shadow = serial_config_pkg::REQ_CTRL_RESET;
                                 next_s.tune_shadow = serial_config_pkg::REQ_TUNE_RESET;
                                 next_s.ctrl_live = serial_config_pkg::REQ_CTRL_RESET;
                                 next_s.tune_live = serial_config_pkg::REQ_TUNE_RESET;
                              end
                           end
                           serial_config_pkg::ADDR_REQ_CTRL: begin
                              next_s.ctrl_shadow = data_byte;
                           end
                           serial_config_pkg::ADDR_REQ_TUNE: begin
                              next_s.tune_shadow = data_byte;
                           end
                           serial_config_pkg::ADDR_TRANSFER: begin
                              // Only the exact command copies the shadows; the bit never stays set.
                              if (data_byte == serial_config_pkg::TRANSFER_GO) begin
                                 next_s.ctrl_live = s.ctrl_shadow;
                                 next_s.tune_live = s.tune_shadow;
                              end
                           end
                           default: begin
                              next_s.addr = s.addr;
                           end
                        endcase
                     end
                     next_s.addr = next_addr;
                     next_s.out_byte = read_reg(next_addr, s);
                     // Fixed lengths return to a fresh instruction; the stream code never ends.
                     if (s.word_len != serial_config_pkg::WL_STREAM) begin
                        if (s.bytes_left == 2'h0) begin
                           next_s.phase = serial_config_pkg::ST_INSTR;
                        end else begin
                           next_s.bytes_left = s.bytes_left - 2'h1;
                        end
                     end
                  end else begin
                     next_s.bit_cnt = s.bit_cnt + 5'h01;
                  end
               end
               default: begin
                  next_s.phase = serial_config_pkg::ST_IDLE;
               end
            endcase
         end
         // Read bits change on falling edges, a full period ahead of the host's sample.
         if (fall) begin
            if (s.phase == serial_config_pkg::ST_DATA && s.rd) begin
               next_s.sdio_oe = 1'b1;
               next_s.sdio_o = s.lsb_first ? s.out_byte[0] : s.out_byte[7];
               next_s.out_byte = s.lsb_first ? {1'b0, s.out_byte[7:1]} : {s.out_byte[6:0], 1'b0};
            end else begin
               next_s.sdio_oe = 1'b0;
            end
         end
      end
   end

   // Single register for the whole record.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s <= S_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Requantizer decode runs only from the live copies, never the shadows.
   requant_status u_requant_status (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .ctrl_in(s.ctrl_live),
      .tune_in(s.tune_live),
      .enable_out(noise_shaping_requantizer_en_out),
      .bw33_out(bw33_mode_out),
      .tuning_word_out(band_tuning_word_out),
      .tuning_valid_out(tuning_valid_out),
      .left_edge_out(left_edge_thousandths_out),
      .atten_out(atten_tenth_db_out),
      .latency_out(latency_cycles_out)
   );

   // Pin and status outputs come straight from the record.
   assign sdio_out = s.sdio_o;
   assign sdio_oe_out = s.sdio_oe;
   assign secondary_function_out = s.secondary;
   assign lsb_first_out = s.lsb_first;

endmodule : serial_config_port
`default_nettype wire

/* File: serial_config_pkg.sv */
// Shared constants for the serial configuration port and the requantizer controls.
// Assumes a single 10 MHz reference clock and a serial master clocked far slower.
package serial_config_pkg;

   // Register addresses as they appear in the 13-bit instruction address field.
   localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
   localparam logic [12:0] ADDR_CHIP_ID = 13'h0001;
   localparam logic [12:0] ADDR_REQ_CTRL = 13'h003C;
   localparam logic [12:0] ADDR_REQ_TUNE = 13'h003E;
   localparam logic [12:0] ADDR_TRANSFER = 13'h00FF;

   // Port configuration register: mirrored nibbles, default and bit positions.
   localparam logic [7:0] PORT_CFG_DEFAULT = 8'h18;
   localparam int unsigned LSB_FIRST_HI = 6;
   localparam int unsigned LSB_FIRST_LO = 1;
   localparam int unsigned SOFT_RST_HI = 5;
   localparam int unsigned SOFT_RST_LO = 2;

   // Requantizer register resets, fields and the transfer command value.
   localparam logic [7:0] REQ_CTRL_RESET = 8'h00;
   localparam logic [7:0] REQ_TUNE_RESET = 8'h00;
   localparam logic [7:0] TRANSFER_GO = 8'h01;
   localparam int unsigned REQ_ENABLE_BIT = 0;
   localparam int unsigned REQ_MODE_LO = 1;
   localparam int unsigned REQ_MODE_HI = 3;
   localparam int unsigned TUNE_HI = 5;
   localparam logic [2:0] MODE_BW22 = 3'h0;
   localparam logic [2:0] MODE_BW33 = 3'h1;

   // Tuning limits and derived figures of the requantizer.
   localparam int unsigned TW_COUNT_BW22 = 57;
   localparam int unsigned TW_COUNT_BW33 = 34;
   localparam int unsigned EDGE_STEP_THOUSANDTHS = 5;
   localparam int unsigned ATTEN_TENTH_DB = 6;
   localparam int unsigned LATENCY_BYPASS = 10;
   localparam int unsigned LATENCY_ACTIVE = 13;

   // Frame geometry.
   localparam int unsigned INSTR_BITS = 16;
   localparam int unsigned WORD_BITS = 8;
   localparam int unsigned INSTR_RW_BIT = 15;
   localparam int unsigned INSTR_WL_HI = 14;
   localparam int unsigned INSTR_WL_LO = 13;
   localparam logic [1:0] WL_STREAM = 2'h3;

   // Chip select idle time before the pins hand over to their secondary use.
   localparam int unsigned SECONDARY_IDLE_CYCLES = 1000;

   // Frame phases, Gray coded along idle, instruction, data.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_INSTR = 2'h1,
      ST_DATA = 2'h3
   } phase_t;

endpackage : serial_config_pkg

/* File: pin_sync.sv */
// Two-stage synchroniser for pin inputs entering the reference clock domain.
// Assumes the inputs are asynchronous levels; the first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // Both stages take the constant reset value; stage1 is read only by sync_out.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stage1 <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : pin_sync
`default_nettype wire

/* File: requant_status.sv */
// Decodes the live requantizer registers into mode, tuning and derived figures.
// Assumes the live registers change only on a transfer command or a soft reset.
`timescale 1ns/10ps
`default_nettype none
module requant_status (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Live register values.
   input wire logic [7:0] ctrl_in,
   input wire logic [7:0] tune_in,
   // Decoded controls.
   output logic enable_out,
   output logic bw33_out,
   output logic [5:0] tuning_word_out,
   output logic tuning_valid_out,
   output logic [8:0] left_edge_out,
   output logic [2:0] atten_out,
   output logic [3:0] latency_out
);

   logic [2:0] mode;
   logic [5:0] tw;
   logic on;

   assign mode = ctrl_in[serial_config_pkg::REQ_MODE_HI:serial_config_pkg::REQ_MODE_LO];
   assign tw = tune_in[serial_config_pkg::TUNE_HI:0];
   assign on = ctrl_in[serial_config_pkg::REQ_ENABLE_BIT];

   // Outputs are registered so downstream logic sees one clean update per transfer.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         enable_out <= 1'b0;
         bw33_out <= 1'b0;
         tuning_word_out <= 6'h00;
         tuning_valid_out <= 1'b1;
         left_edge_out <= 9'h000;
         atten_out <= 3'h0;
         latency_out <= 4'(serial_config_pkg::LATENCY_BYPASS);
      end else begin
         enable_out <= on;
         bw33_out <= (mode == serial_config_pkg::MODE_BW33);
         tuning_word_out <= tw;
         // Codes outside the mode's range are flagged, not clipped. Unknown modes are invalid.
         if (mode == serial_config_pkg::MODE_BW22) begin
            tuning_valid_out <= (32'(tw) < serial_config_pkg::TW_COUNT_BW22);
         end else if (mode == serial_config_pkg::MODE_BW33) begin
            tuning_valid_out <= (32'(tw) < serial_config_pkg::TW_COUNT_BW33);
         end else begin
            tuning_valid_out <= 1'b0;
         end
         left_edge_out <= 9'(32'(tw) * serial_config_pkg::EDGE_STEP_THOUSANDTHS);
         atten_out <= on ? 3'(serial_config_pkg::ATTEN_TENTH_DB) : 3'h0;
         latency_out <= on ? 4'(serial_config_pkg::LATENCY_ACTIVE)
                           : 4'(serial_config_pkg::LATENCY_BYPASS);
      end
   end

endmodule : requant_status
`default_nettype wire

/* File: scp_monitor.sv */
// Concurrent checks on the outputs of the serial configuration port.
// Assumes one reference clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module scp_monitor #(
   parameter int unsigned SECONDARY_IDLE = 8
) (
   // Clock, reset and pins.
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic chip_select_n_in,
   input wire logic sdio_out,
   input wire logic sdio_oe_out,
   input wire logic secondary_function_out,
   // Requantizer controls.
   input wire logic noise_shaping_requantizer_en_out,
   input wire logic bw33_mode_out,
   input wire logic [5:0] band_tuning_word_out,
   input wire logic tuning_valid_out,
   input wire logic [8:0] left_edge_thousandths_out,
   input wire logic [2:0] atten_tenth_db_out,
   input wire logic [3:0] latency_cycles_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   int unsigned idle_cnt;
   // Raw cycles of chip select high; the margin covers the design's synchroniser lag.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !chip_select_n_in) idle_cnt <= 0;
      else if (idle_cnt < SECONDARY_IDLE + 8) idle_cnt <= idle_cnt + 1;
   end
   property p_atten; atten_tenth_db_out == (noise_shaping_requantizer_en_out ? 3'h6 : 3'h0); endproperty
   a_atten: assert property (p_atten) else $error("attenuation off");
   property p_lat; latency_cycles_out == (noise_shaping_requantizer_en_out ? 4'hD : 4'hA); endproperty
   a_lat: assert property (p_lat) else $error("latency off");
   property p_edge; left_edge_thousandths_out == 9'(band_tuning_word_out) * 9'h005; endproperty
   a_edge: assert property (p_edge) else $error("band edge off");
   property p_v22; !bw33_mode_out && tuning_valid_out |-> band_tuning_word_out < 6'h39; endproperty
   a_v22: assert property (p_v22) else $error("narrow mode range");
   property p_v33; bw33_mode_out |-> tuning_valid_out == (band_tuning_word_out < 6'h22); endproperty
   a_v33: assert property (p_v33) else $error("wide mode range");
   property p_oe_idle; chip_select_n_in [*6] |-> !sdio_oe_out; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("data driven while deselected");
   property p_oe_rise; $rose(sdio_oe_out) |-> !$past(sclk_in, 3) && !chip_select_n_in; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("turnaround off a falling edge");
   property p_bit; sdio_oe_out && $past(sdio_oe_out) && $changed(sdio_out) |-> !$past(sclk_in, 3); endproperty
   a_bit: assert property (p_bit) else $error("read bit moved off a falling edge");
   property p_sec_on; idle_cnt == SECONDARY_IDLE + 6 |-> secondary_function_out; endproperty
   a_sec_on: assert property (p_sec_on) else $error("secondary use late");
   property p_sec_off; $fell(chip_select_n_in) |-> ##[1:5] !secondary_function_out; endproperty
   a_sec_off: assert property (p_sec_off) else $error("secondary use kept");
   property p_sec_oe; secondary_function_out |-> !sdio_oe_out; endproperty
   a_sec_oe: assert property (p_sec_oe) else $error("pin driven in secondary use");
endmodule : scp_monitor
bind serial_config_port scp_monitor #(.SECONDARY_IDLE(SECONDARY_IDLE)) u_mon (.ref_clk_in(ref_clk_in),
   .rst_in(rst_in), .sclk_in(sclk_in), .chip_select_n_in(chip_select_n_in), .sdio_out(sdio_out),
   .sdio_oe_out(sdio_oe_out), .secondary_function_out(secondary_function_out),
   .noise_shaping_requantizer_en_out(noise_shaping_requantizer_en_out), .bw33_mode_out(bw33_mode_out),
   .band_tuning_word_out(band_tuning_word_out), .tuning_valid_out(tuning_valid_out),
   .left_edge_thousandths_out(left_edge_thousandths_out), .atten_tenth_db_out(atten_tenth_db_out),
   .latency_cycles_out(latency_cycles_out));
`default_nettype wire

/* File: spi_host_model.sv */
// Serial master model: drives clock, chip select and data, and samples read bits.
// Assumes a reference clock; one serial bit lasts eight reference cycles.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   // Pacing clock.
   input wire logic ref_clk_in,
   // Pins toward the device.
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdo_out,
   output logic sdo_oe_out,
   input wire logic sdio_pin_in
);
   logic lsb;
   // Idle: deselected, clock parked low, line released.
   initial begin
      lsb = 1'b0;
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdo_out = 1'b0;
      sdo_oe_out = 1'b0;
   end
   // Drive on the fall, device samples on the rise, read late in the high half.
   task automatic bitx(input logic b, output logic r);
      sdo_out <= b;
      sclk_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      r = sdio_pin_in;
   endtask : bitx
   // Shifts n bits in the current order; a stall raises chip select at each byte end.
   task automatic shift(input logic [15:0] v, input int n, input bit stall, output logic [15:0] r);
      logic b;
      r = '0;
      for (int i = 0; i < n; i++) begin
         bitx(v[lsb ? i : n - 1 - i], b);
         r[lsb ? i : n - 1 - i] = b;
         if (stall && i % 8 == 7) begin
            sclk_out <= 1'b0;
            cs_n_out <= 1'b1;
            repeat (12) @(posedge ref_clk_in);
            cs_n_out <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
         end
      end
   endtask : shift
   // One frame of nb bytes; hold keeps chip select low into the next frame.
   task automatic frame(input logic rd, input logic [12:0] adr, input int nb, input logic [23:0] wd,
                        input bit stall, input bit hold, output logic [23:0] rdata);
      logic [15:0] r;
      rdata = '0;
      sdo_oe_out <= 1'b1;
      cs_n_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      shift({rd, 2'(nb - 1), adr}, 16, stall, r);
      sdo_oe_out <= !rd;
      for (int k = 0; k < nb; k++) begin
         shift(16'(wd[8 * (nb - 1 - k) +: 8]), 8, stall, r);
         rdata[8 * (nb - 1 - k) +: 8] = r[7:0];
      end
      sclk_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      if (!hold) cs_n_out <= 1'b1;
      sdo_oe_out <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the serial configuration port.
// Assumes the host model drives the pins; the released line toggles every cycle.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int unsigned IDLE = 8;
   localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary identification value.
   logic ref_clk_in, rst_in, sclk, cs_n, host_d, host_oe, sdio_pin, dout, oe, sec, lsb_o, en, bw33, valid;
   logic idle_tgl = 1'b0;
   logic [5:0] tw;
   logic [8:0] edge_th;
   logic [2:0] atten;
   logic [3:0] lat;
   logic [23:0] rd;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   // Clock, and a released line that never holds a stale bit.
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) idle_tgl <= !idle_tgl;
   assign sdio_pin = oe ? dout : (host_oe ? host_d : idle_tgl);
   spi_host_model u_host (.ref_clk_in(ref_clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .sdo_out(host_d),
      .sdo_oe_out(host_oe), .sdio_pin_in(sdio_pin));
   serial_config_port #(.SECONDARY_IDLE(IDLE), .CHIP_ID(ID_VAL)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .sclk_in(sclk), .chip_select_n_in(cs_n), .sdio_in(sdio_pin), .sdio_out(dout), .sdio_oe_out(oe),
      .secondary_function_out(sec), .lsb_first_out(lsb_o), .noise_shaping_requantizer_en_out(en),
      .bw33_mode_out(bw33), .band_tuning_word_out(tw), .tuning_valid_out(valid),
      .left_edge_thousandths_out(edge_th), .atten_tenth_db_out(atten), .latency_cycles_out(lat));
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   task automatic wr(input logic [12:0] a, input int nb, input logic [23:0] d, input bit hold);
      u_host.frame(1'b0, a, nb, d, 1'b0, hold, rd);
   endtask : wr
   task automatic rdchk(input logic [12:0] a, input int nb, input logic [23:0] exp);
      u_host.frame(1'b1, a, nb, 24'h00_0000, 1'b0, 1'b0, rd);
      cmp(rd, exp, "readback");
   endtask : rdchk
   // Expected band figures are worked out here from enable and tuning word.
   task automatic chk_req(input logic e, input logic b, input logic [5:0] w, input logic v);
      cmp(en, e, "enable");
      cmp(bw33, b, "wide mode");
      cmp(tw, w, "tuning");
      cmp(valid, v, "valid");
      cmp(edge_th, 9'(w) * 9'h005, "edge");
      cmp(atten, e ? 3'h6 : 3'h0, "atten");
      cmp(lat, e ? 4'hD : 4'hA, "latency");
   endtask : chk_req
   task automatic t_reset();
      chk_req(1'b0, 1'b0, 6'h00, 1'b1);
      cmp(lsb_o, 1'b0, "order");
      repeat (16) @(posedge ref_clk_in);
      cmp(sec, 1'b1, "secondary");
      rdchk(13'h0001, 1, 24'(ID_VAL));
   endtask : t_reset
   // Shadowed writes stay hidden until a transfer of exactly 0x01.
   task automatic t_shadow();
      wr(13'h003E, 3, 24'h38_0001, 1'b0);
      chk_req(1'b0, 1'b0, 6'h00, 1'b1);
      wr(13'h00FF, 1, 24'h00_0002, 1'b0);
      chk_req(1'b0, 1'b0, 6'h00, 1'b1);
      wr(13'h00FF, 1, 24'h00_0001, 1'b0);
      chk_req(1'b1, 1'b0, 6'h38, 1'b1);
      rdchk(13'h003E, 3, 24'h38_0001);
      rdchk(13'h00FF, 1, 24'h00_0000);
   endtask : t_shadow
   // Mode and range table; each pair of frames shares one chip select.
   task automatic t_modes();
      logic [7:0] c [4] = '{8'h03, 8'h03, 8'h01, 8'h0E};
      logic [5:0] w [4] = '{6'h21, 6'h22, 6'h39, 6'h05};
      logic v [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wr(13'h003E, 3, {2'h0, w[i], 8'h00, c[i]}, 1'b1);
         wr(13'h00FF, 1, 24'h00_0001, 1'b0);
         chk_req(c[i][0], c[i][3:1] == 3'h1, w[i], v[i]);
      end
   endtask : t_modes
   // Bit order switch, stalled frame, ignored clocks while deselected, soft reset.
   task automatic t_order();
      logic [15:0] r;
      wr(13'h0000, 1, 24'h00_0042, 1'b0);
      cmp(lsb_o, 1'b1, "order");
      u_host.lsb = 1'b1;
      u_host.frame(1'b0, 13'h003C, 2, 24'h00_0300, 1'b1, 1'b0, rd);
      u_host.shift(16'h003C, 16, 1'b0, r);
      u_host.shift(16'h00FF, 8, 1'b0, r);
      // A byte cut mid-way must be dropped so the next instruction starts clean.
      u_host.cs_n_out <= 1'b0;
      u_host.shift(16'h0000, 5, 1'b0, r);
      u_host.cs_n_out <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      rdchk(13'h003C, 1, 24'h00_0003);
      chk_req(1'b0, 1'b0, 6'h05, 1'b0);
      wr(13'h0000, 1, 24'h00_0024, 1'b0);
      cmp(lsb_o, 1'b0, "order");
      chk_req(1'b0, 1'b0, 6'h00, 1'b1);
      u_host.lsb = 1'b0;
      rdchk(13'h003C, 1, 24'h00_0000);
   endtask : t_order
   // Cuts a hang short; the full sequence needs about 5000 cycles.
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end
   initial begin
      rst_in = 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      t_reset();
      t_shadow();
      t_modes();
      t_order();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
